//--- shared/ldc_pkg.sv
// Notes on behaviour
// - Serial port config register resets to 02h: normal power, all else zero.
// - Config bit 7 enables bank switching of the extended serial registers.
// - Config bit 2 is read-only and shows a serial transfer in progress.
// - Bit 1 clear with device active stops port clock, outputs to defaults.
// - In low power the ring indicate input can still raise an interrupt.
// - Low power keeps serial registers and their access; only deactivation blocks.
// - Bit 1 set (default) enables the port clock; port works while active.
// - Bit 0 set while inactive floats all port outputs; clear leaves them driven.
// - Wake-up activate at 30h resets 00h; bit 0 clear blocks run-time access.
// - Deactivated wake-up device keeps registers and keeps detecting wake events.
// - Base address pair 60h/61h reset 00h; low bits 4..0 read zero.
// - Wake-up interrupt number at 70h is read/write, reset 00h.
// - Interrupt type at 71h resets 03h; only bit 1 writable.
// - Indices 74h and 75h read 04h always: no DMA channel.
package ldc_pkg;
  localparam int LDC_AW = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0] LDC_IDX_ACT = 8'h30;
  localparam logic [7:0] LDC_IDX_BAH = 8'h60;
  localparam logic [7:0] LDC_IDX_BAL = 8'h61;
  localparam logic [7:0] LDC_IDX_IRQN = 8'h70;
  localparam logic [7:0] LDC_IDX_IRQT = 8'h71;
  localparam logic [7:0] LDC_IDX_DMA_A = 8'h74;
  localparam logic [7:0] LDC_IDX_DMA_B = 8'h75;
  localparam logic [7:0] LDC_IDX_INT_STAT = 8'h80;
  localparam logic [7:0] LDC_IDX_INT_MASK = 8'h81;
  localparam logic [7:0] LDC_IDX_SP_CFG = 8'hf0;
  // Reset values
  localparam logic [7:0] LDC_RST_ACT = 8'h00;
  localparam logic [7:0] LDC_RST_BAH = 8'h00;
  localparam logic [7:0] LDC_RST_BAL = 8'h00;
  localparam logic [7:0] LDC_RST_IRQN = 8'h00;
  localparam logic [7:0] LDC_RST_IRQT = 8'h03;
  localparam logic [7:0] LDC_VAL_NO_DMA = 8'h04;
  localparam logic [7:0] LDC_RST_SP_CFG = 8'h02;
  localparam logic [2:0] LDC_RST_INT = 3'h0;
  // Field positions
  localparam int LDC_SP_BANK_BIT = 7;
  localparam int LDC_SP_BUSY_BIT = 2;
  localparam int LDC_SP_PWR_BIT = 1;
  localparam int LDC_SP_HIZ_BIT = 0;
  localparam int LDC_ACT_BIT = 0;
  localparam int LDC_IRQT_WR_BIT = 1;
  localparam logic [7:0] LDC_BAL_WR_MASK = 8'he0;
  // Interrupt status bits
  localparam int LDC_INT_RING = 0;
  localparam int LDC_INT_DONE = 1;
  localparam int LDC_INT_WAKE = 2;
  localparam int LDC_INT_N = 3;
endpackage

//--- rtl/ldc_regs.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module ldc_regs (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ldc_pkg::LDC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial port state and control
  input wire logic sp_active,
  input wire logic sp_busy,
  input wire logic ring_indicate_input,
  output logic sp_bank_sw_en,
  output logic sp_clk_en,
  output logic sp_out_default,
  output logic sp_out_hiz,
  // Wake-up controller
  input wire logic wake_event,
  output logic wake_runtime_en,
  output logic [15:0] wake_base_addr,
  output logic [7:0] wake_irq_num,
  output logic wake_irq_type,
  // Interrupt
  output logic irq
);
  import ldc_pkg::*;

  logic [7:0] act_q;
  logic [7:0] bah_q;
  logic [7:0] bal_q;
  logic [7:0] irqn_q;
  logic [7:0] irqt_q;
  logic [7:0] spcfg_q;
  logic [LDC_INT_N-1:0] stat_q;
  logic [LDC_INT_N-1:0] mask_q;
  logic [LDC_INT_N-1:0] ev_d;
  logic ring_prev_q;
  logic busy_prev_q;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] idx;

  // Index of the word addressed; low two bits are byte lanes only
  function automatic logic [7:0] reg_idx(input logic [LDC_AW-1:0] a);
    return a[9:2];
  endfunction

  // Matches one register index, whole address checked so aliases miss
  function automatic logic hit(input logic [LDC_AW-1:0] a, input logic [7:0] i);
    return (a[LDC_AW-1:10] == 2'h0) && (a[1:0] == 2'h0) && (reg_idx(a) == i);
  endfunction

  // Zero wait state: every access completes in its first access cycle
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign idx = reg_idx(paddr);
  assign pready = 1'b1;

  // Address decode; unmapped words answer with an error
  always_comb begin
    mapped = hit(paddr, LDC_IDX_ACT) | hit(paddr, LDC_IDX_BAH) |
             hit(paddr, LDC_IDX_BAL) | hit(paddr, LDC_IDX_IRQN) |
             hit(paddr, LDC_IDX_IRQT) | hit(paddr, LDC_IDX_DMA_A) |
             hit(paddr, LDC_IDX_DMA_B) | hit(paddr, LDC_IDX_INT_STAT) |
             hit(paddr, LDC_IDX_INT_MASK) | hit(paddr, LDC_IDX_SP_CFG);
  end
  assign pslverr = acc & ~mapped;

  // Wake-up activate; config space stays reachable, only run-time space is gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= LDC_RST_ACT;
    end else if (wr && hit(paddr, LDC_IDX_ACT)) begin
      act_q <= {7'h00, pwdata[LDC_ACT_BIT]};
    end
  end
  assign wake_runtime_en = act_q[LDC_ACT_BIT];

  // Base address pair; deactivation does not disturb contents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bah_q <= LDC_RST_BAH;
      bal_q <= LDC_RST_BAL;
    end else if (wr) begin
      if (hit(paddr, LDC_IDX_BAH)) begin
        bah_q <= pwdata[7:0];
      end
      if (hit(paddr, LDC_IDX_BAL)) begin
        bal_q <= pwdata[7:0] & LDC_BAL_WR_MASK;
      end
    end
  end
  assign wake_base_addr = {bah_q, bal_q};

  // Interrupt number and type
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqn_q <= LDC_RST_IRQN;
      irqt_q <= LDC_RST_IRQT;
    end else if (wr) begin
      if (hit(paddr, LDC_IDX_IRQN)) begin
        irqn_q <= pwdata[7:0];
      end
      if (hit(paddr, LDC_IDX_IRQT)) begin
        irqt_q[LDC_IRQT_WR_BIT] <= pwdata[LDC_IRQT_WR_BIT];
      end
    end
  end
  assign wake_irq_num = irqn_q;
  assign wake_irq_type = irqt_q[LDC_IRQT_WR_BIT];

  // Serial port config; busy and reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spcfg_q <= LDC_RST_SP_CFG;
    end else if (wr && hit(paddr, LDC_IDX_SP_CFG)) begin
      spcfg_q[LDC_SP_BANK_BIT] <= pwdata[LDC_SP_BANK_BIT];
      spcfg_q[LDC_SP_PWR_BIT] <= pwdata[LDC_SP_PWR_BIT];
      spcfg_q[LDC_SP_HIZ_BIT] <= pwdata[LDC_SP_HIZ_BIT];
    end
  end

  // Serial port controls derived from config and activation
  assign sp_bank_sw_en = spcfg_q[LDC_SP_BANK_BIT];
  assign sp_clk_en = spcfg_q[LDC_SP_PWR_BIT];
  assign sp_out_default = sp_active & ~spcfg_q[LDC_SP_PWR_BIT];
  assign sp_out_hiz = spcfg_q[LDC_SP_HIZ_BIT] & ~sp_active;

  // Edge history for the event detectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_prev_q <= 1'b0;
      busy_prev_q <= 1'b0;
    end else begin
      ring_prev_q <= ring_indicate_input;
      busy_prev_q <= sp_busy;
    end
  end

  // Ring and wake detection ignore power mode and activation on purpose
  always_comb begin
    ev_d = '0;
    ev_d[LDC_INT_RING] = ring_indicate_input & ~ring_prev_q;
    ev_d[LDC_INT_DONE] = busy_prev_q & ~sp_busy;
    ev_d[LDC_INT_WAKE] = wake_event;
  end

  // Sticky status cleared by a read; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= LDC_RST_INT;
    end else if (rd && hit(paddr, LDC_IDX_INT_STAT)) begin
      stat_q <= ev_d;
    end else begin
      stat_q <= stat_q | ev_d;
    end
  end

  // Mask: a set bit lets that status bit reach irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= LDC_RST_INT;
    end else if (wr && hit(paddr, LDC_IDX_INT_MASK)) begin
      mask_q <= pwdata[LDC_INT_N-1:0];
    end
  end
  assign irq = |(stat_q & mask_q);

  // Read mux; only in the access phase so idle bus reads zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (hit(paddr, LDC_IDX_ACT)) begin
        prdata[7:0] = act_q;
      end else if (hit(paddr, LDC_IDX_BAH)) begin
        prdata[7:0] = bah_q;
      end else if (hit(paddr, LDC_IDX_BAL)) begin
        prdata[7:0] = bal_q;
      end else if (hit(paddr, LDC_IDX_IRQN)) begin
        prdata[7:0] = irqn_q;
      end else if (hit(paddr, LDC_IDX_IRQT)) begin
        prdata[7:0] = irqt_q;
      end else if (hit(paddr, LDC_IDX_DMA_A) || hit(paddr, LDC_IDX_DMA_B)) begin
        prdata[7:0] = LDC_VAL_NO_DMA;
      end else if (hit(paddr, LDC_IDX_INT_STAT)) begin
        prdata[LDC_INT_N-1:0] = stat_q;
      end else if (hit(paddr, LDC_IDX_INT_MASK)) begin
        prdata[LDC_INT_N-1:0] = mask_q;
      end else if (hit(paddr, LDC_IDX_SP_CFG)) begin
        // Reserved bits 6..3 stay zero; busy is live state
        prdata[LDC_SP_BANK_BIT] = spcfg_q[LDC_SP_BANK_BIT];
        prdata[LDC_SP_BUSY_BIT] = sp_busy;
        prdata[LDC_SP_PWR_BIT] = spcfg_q[LDC_SP_PWR_BIT];
        prdata[LDC_SP_HIZ_BIT] = spcfg_q[LDC_SP_HIZ_BIT];
      end
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sp_cfg_reserved;
    rd && hit(paddr, LDC_IDX_SP_CFG) |-> prdata[6:3] == 4'h0 && prdata[31:8] == 24'h0;
  endproperty
  a_sp_cfg_reserved: assert property (p_sp_cfg_reserved)
    else $error("reserved config bits not zero");

  property p_busy_live;
    rd && hit(paddr, LDC_IDX_SP_CFG) |-> prdata[LDC_SP_BUSY_BIT] == sp_busy;
  endproperty
  a_busy_live: assert property (p_busy_live)
    else $error("busy bit does not follow transfer state");

  property p_low_power;
    sp_active && !spcfg_q[LDC_SP_PWR_BIT] |-> sp_out_default && !sp_clk_en;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power not applied");

  property p_clk_on;
    spcfg_q[LDC_SP_PWR_BIT] |-> sp_clk_en && !sp_out_default;
  endproperty
  a_clk_on: assert property (p_clk_on)
    else $error("port clock off in normal mode");

  property p_hiz;
    sp_out_hiz == (spcfg_q[LDC_SP_HIZ_BIT] && !sp_active);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("high impedance control wrong");

  property p_ring_irq;
    ring_indicate_input && !ring_prev_q && mask_q[LDC_INT_RING] |=> irq;
  endproperty
  a_ring_irq: assert property (p_ring_irq)
    else $error("ring edge did not raise interrupt");

  property p_wake_inactive;
    wake_event && !act_q[LDC_ACT_BIT] |=> stat_q[LDC_INT_WAKE];
  endproperty
  a_wake_inactive: assert property (p_wake_inactive)
    else $error("wake event lost while inactive");

  property p_runtime_gate;
    wr && hit(paddr, LDC_IDX_ACT) |=> wake_runtime_en == $past(pwdata[LDC_ACT_BIT]);
  endproperty
  a_runtime_gate: assert property (p_runtime_gate)
    else $error("run-time access gate wrong");

  property p_bal_low;
    bal_q[4:0] == 5'h00;
  endproperty
  a_bal_low: assert property (p_bal_low)
    else $error("base low bits not zero");

  property p_irqt_ro;
    irqt_q[7:2] == 6'h00 && irqt_q[0];
  endproperty
  a_irqt_ro: assert property (p_irqt_ro)
    else $error("interrupt type read-only bits changed");

  property p_no_dma;
    rd && (hit(paddr, LDC_IDX_DMA_A) || hit(paddr, LDC_IDX_DMA_B)) |-> prdata == 32'h4;
  endproperty
  a_no_dma: assert property (p_no_dma)
    else $error("dma report not 04h");

  property p_irqn_write;
    wr && hit(paddr, LDC_IDX_IRQN) |=> irqn_q == $past(pwdata[7:0]);
  endproperty
  a_irqn_write: assert property (p_irqn_write)
    else $error("interrupt number write lost");

  property p_bank;
    wr && hit(paddr, LDC_IDX_SP_CFG) |=> sp_bank_sw_en == $past(pwdata[LDC_SP_BANK_BIT]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank enable not written");

  property p_act_upper;
    act_q[7:1] == 7'h00;
  endproperty
  a_act_upper: assert property (p_act_upper)
    else $error("activate upper bits not zero");

  property p_bah_write;
    wr && hit(paddr, LDC_IDX_BAH) |=> wake_base_addr[15:8] == $past(pwdata[7:0]);
  endproperty
  a_bah_write: assert property (p_bah_write)
    else $error("base high write lost");

  // Only bits 7..5 of the low half may take the written value
  property p_bal_write;
    wr && hit(paddr, LDC_IDX_BAL) |=>
      wake_base_addr[7:0] == ($past(pwdata[7:0]) & LDC_BAL_WR_MASK);
  endproperty
  a_bal_write: assert property (p_bal_write)
    else $error("base low write wrong");

  property p_irqt_write;
    wr && hit(paddr, LDC_IDX_IRQT) |=> wake_irq_type == $past(pwdata[LDC_IRQT_WR_BIT]);
  endproperty
  a_irqt_write: assert property (p_irqt_write)
    else $error("interrupt type bit not written");

  property p_pwr_write;
    wr && hit(paddr, LDC_IDX_SP_CFG) |=> sp_clk_en == $past(pwdata[LDC_SP_PWR_BIT]);
  endproperty
  a_pwr_write: assert property (p_pwr_write)
    else $error("power mode not written");

  property p_hiz_write;
    wr && hit(paddr, LDC_IDX_SP_CFG) |=>
      spcfg_q[LDC_SP_HIZ_BIT] == $past(pwdata[LDC_SP_HIZ_BIT]);
  endproperty
  a_hiz_write: assert property (p_hiz_write)
    else $error("float control not written");

  // Low power must not hide the stored bits from software
  property p_cfg_read;
    rd && hit(paddr, LDC_IDX_SP_CFG) |->
      prdata[LDC_SP_BANK_BIT] == sp_bank_sw_en && prdata[LDC_SP_PWR_BIT] == sp_clk_en;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config read does not show stored bits");

  // Status bits only fall on a status read
  property p_stat_sticky;
    !(rd && hit(paddr, LDC_IDX_INT_STAT)) |=> (stat_q & $past(stat_q)) == $past(stat_q);
  endproperty
  a_stat_sticky: assert property (p_stat_sticky)
    else $error("status bit lost without a read");

  property p_stat_clear;
    rd && hit(paddr, LDC_IDX_INT_STAT) |=> stat_q == $past(ev_d);
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status read did not clear");

  property p_done_event;
    busy_prev_q && !sp_busy |=> stat_q[LDC_INT_DONE];
  endproperty
  a_done_event: assert property (p_done_event)
    else $error("end of transfer not flagged");

  property p_mask_write;
    wr && hit(paddr, LDC_IDX_INT_MASK) |=> mask_q == $past(pwdata[LDC_INT_N-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write lost");

  // Misaligned words are refused even when the index would match
  property p_misaligned;
    acc && (paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_misaligned: assert property (p_misaligned)
    else $error("misaligned access not refused");

  // A refused write must leave every stored register alone
  property p_unmapped_write;
    wr && !mapped |=> $stable(act_q) && $stable(bah_q) && $stable(bal_q) &&
      $stable(irqn_q) && $stable(irqt_q) && $stable(spcfg_q) && $stable(mask_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("refused write changed a register");

  c_low_power: cover property (sp_active && sp_out_default);
  c_irq: cover property (!irq ##1 irq);
  c_stat_clear: cover property (rd && hit(paddr, LDC_IDX_INT_STAT) && stat_q != 3'h0);
  c_hiz: cover property (sp_out_hiz);
  c_busy_read: cover property (rd && hit(paddr, LDC_IDX_SP_CFG) && sp_busy);
endmodule

//--- bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ldc_pkg::*;
  // Register order shared by the tables below
  localparam logic [7:0][7:0] IDXS = {LDC_IDX_ACT, LDC_IDX_BAH, LDC_IDX_BAL, LDC_IDX_IRQN,
    LDC_IDX_IRQT, LDC_IDX_DMA_A, LDC_IDX_DMA_B, LDC_IDX_SP_CFG};
  localparam logic [7:0][7:0] RSTV = {8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h04, 8'h02};
  localparam logic [7:0][7:0] ONES = {8'h01, 8'hff, 8'he0, 8'hff, 8'h03, 8'h04, 8'h04, 8'h83};
  localparam logic [7:0][7:0] ZERO = {8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h04, 8'h00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [LDC_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sp_active = 1'b0;
  logic sp_busy = 1'b0;
  logic ring = 1'b0;
  logic wake_event = 1'b0;
  logic bank_en, clk_en, out_def, out_hiz, run_en, wtype, irq;
  logic [15:0] base;
  logic [7:0] irqn;
  logic [31:0] rdv;
  logic err;
  int miscompares = 0;
  int checked = 0;

  ldc_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sp_active(sp_active), .sp_busy(sp_busy),
    .ring_indicate_input(ring), .sp_bank_sw_en(bank_en), .sp_clk_en(clk_en),
    .sp_out_default(out_def), .sp_out_hiz(out_hiz), .wake_event(wake_event),
    .wake_runtime_en(run_en), .wake_base_addr(base), .wake_irq_num(irqn),
    .wake_irq_type(wtype), .irq(irq));

  // 50 MHz clock
  always #10 pclk = ~pclk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [LDC_AW-1:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, {2'b00, idx, 2'b00}, {24'h0, v});
  endtask

  task automatic rd(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
    chk(name, rdv, {24'h0, exp});
    chk("slverr", err, 1'b0);
  endtask

  // Wait for the edge's updates to land before looking at outputs
  task automatic settle();
    @(negedge pclk);
  endtask

  task automatic end_of_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd("reset", IDXS[i], RSTV[i]);
    for (int i = 0; i < 8; i++) wr(IDXS[i], 8'hff);
    for (int i = 0; i < 8; i++) rd("ones", IDXS[i], ONES[i]);
    settle();
    chk("bank", bank_en, 1);
    chk("clk", clk_en, 1);
    chk("run_en", run_en, 1);
    chk("base", base, 16'hffe0);
    chk("irqn", irqn, 8'hff);
    chk("itype", wtype, 1);
    for (int i = 0; i < 8; i++) wr(IDXS[i], 8'h00);
    @(posedge pclk);
    sp_active <= 1'b1;
    for (int i = 0; i < 8; i++) rd("zero", IDXS[i], ZERO[i]);
    settle();
    chk("bank0", bank_en, 0);
    chk("clk0", clk_en, 0);
    chk("def", out_def, 1);
    chk("run0", run_en, 0);
    chk("itype0", wtype, 0);
    wr(LDC_IDX_BAH, 8'h12);
    rd("bah_inact", LDC_IDX_BAH, 8'h12);
    wr(LDC_IDX_SP_CFG, 8'h01);
    settle();
    chk("hiz_act", out_hiz, 0);
    @(posedge pclk);
    sp_active <= 1'b0;
    settle();
    chk("hiz", out_hiz, 1);
    chk("def_inact", out_def, 0);
    // Unmapped index and misaligned word are refused
    apb(1'b0, 12'h100, 32'h0);
    chk("unmap_err", err, 1);
    chk("unmap_rd", rdv, 0);
    apb(1'b1, 12'h3c1, 32'h80);
    chk("misal_err", err, 1);
    rd("cfg_kept", LDC_IDX_SP_CFG, 8'h01);
    // Busy bit follows transfer in progress
    @(posedge pclk);
    sp_busy <= 1'b1;
    rd("busy", LDC_IDX_SP_CFG, 8'h05);
    wr(LDC_IDX_INT_MASK, 8'h07);
    @(posedge pclk);
    sp_busy <= 1'b0;
    rd("done", LDC_IDX_INT_STAT, 8'h02);
    rd("clr", LDC_IDX_INT_STAT, 8'h00);
    // Ring in low power and wake event while deactivated still flag
    @(posedge pclk);
    ring <= 1'b1;
    settle();
    settle();
    chk("irq_ring", irq, 1);
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    rd("stat", LDC_IDX_INT_STAT, 8'h05);
    settle();
    chk("irq_clr", irq, 0);
    // Masked event sets status but not the line
    wr(LDC_IDX_INT_MASK, 8'h03);
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    settle();
    settle();
    chk("irq_mask", irq, 0);
    rd("stat_m", LDC_IDX_INT_STAT, 8'h04);
    rd("mask", LDC_IDX_INT_MASK, 8'h03);
    end_of_test();
  end
endmodule
